// File: sfa_pkg.sv
// sfa_pkg: constants and types for the status flag aggregator.
// assumes a single 100 MHz ref_clk domain and synchronous reset.
package sfa_pkg;
   // alarm classes A..F occupy bits 0..5
   localparam int         NUM_CLASSES    = 6;
   localparam logic [5:0] ALL_MASK       = 6'h3F;
   localparam logic [5:0] WARN_MASK      = 6'h03;
   localparam logic [5:0] CRIT_MASK      = 6'h3C;
   localparam logic [5:0] CENTRAL_MASK   = 6'h3E;
   localparam logic [5:0] NEWALM_MASK    = 6'h3E;
   // timing
   localparam int         CLK_PERIOD_NS  = 10;
   localparam int         MS_NS          = 1000000;
   localparam int         MS_TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int         ACK_PULSE_MS   = 40;
   localparam int         MS_CNT_W       = 17;
   localparam int         TIME_W         = 16;
   localparam int         VOLT_W         = 16;
   // remote control word and cascaded results
   localparam int         NUM_REMOTE     = 16;
   localparam int         CASC_FIRST     = 80;
   localparam int         CASC_LAST      = 99;
   localparam int         CASC_COUNT     = CASC_LAST - CASC_FIRST + 1;
   // reset and fixed values
   localparam logic       FLAG_RST       = 1'h0;
   localparam logic       LM_FALSE       = 1'h0;
   localparam logic       LM_TRUE        = 1'h1;

   typedef logic [4:0] sfa_casc_idx_t;
   typedef enum {CASC_SCAN, CASC_PUBLISH} sfa_casc_state_e;
endpackage : sfa_pkg

// File: sfa_casc_if.sv
// sfa_casc_if: links the cascade sequencer to the top module.
// assumes the equation engine answers val in the same cycle as idx.
interface sfa_casc_if;
   import sfa_pkg::*;
   sfa_casc_idx_t         idx;
   logic                  val;
   logic [CASC_COUNT-1:0] work;
   logic [CASC_COUNT-1:0] results;
   logic                  pass_done;

   modport ctrl (input val, output idx, output work, output results, output pass_done);
   modport user (output val, input idx, input work, input results, input pass_done);
endinterface : sfa_casc_if

// File: sfa_cascade.sv
// sfa_cascade: steps through cascaded equation results in index order.
// assumes the outside engine evaluates the equation named by idx from
// work (results of lower indices already updated in this pass).
module sfa_cascade
   import sfa_pkg::*;
(
   // clock and control
   input  wire logic  ref_clk,
   input  wire logic  reset,
   input  wire logic  clk_en,
   // sequencer side of the link
   sfa_casc_if.ctrl   cif
);
   import sfa_pkg::*;

   localparam sfa_casc_idx_t IDX_LAST = sfa_casc_idx_t'(CASC_COUNT - 1);

   sfa_casc_state_e       state_q;
   sfa_casc_idx_t         idx_q;
   logic [CASC_COUNT-1:0] work_q;
   logic [CASC_COUNT-1:0] results_q;
   logic                  done_q;

   // scan lowest index first, then publish the whole pass
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_q <= CASC_SCAN;
         idx_q   <= '0;
      end
      else if (clk_en)
      begin
         case (state_q)
            CASC_SCAN:
            begin
               if (idx_q == IDX_LAST)
               begin
                  state_q <= CASC_PUBLISH;
                  idx_q   <= '0;
               end
               else
               begin
                  idx_q <= idx_q + 5'h1;
               end
            end
            CASC_PUBLISH: state_q <= CASC_SCAN;
            default:      state_q <= CASC_SCAN;
         endcase
      end
   end

   // working copy feeds later equations of the same pass
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         work_q <= '0;
      else if (clk_en && state_q == CASC_SCAN)
         work_q[idx_q] <= cif.val;
   end

   // published results change only between passes
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         results_q <= '0;
         done_q    <= FLAG_RST;
      end
      else if (clk_en)
      begin
         done_q <= (state_q == CASC_PUBLISH);
         if (state_q == CASC_PUBLISH)
            results_q <= work_q;
      end
   end

   assign cif.idx       = idx_q;
   assign cif.work      = work_q;
   assign cif.results   = results_q;
   assign cif.pass_done = done_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   property p_casc_step;
      clk_en && state_q == CASC_SCAN && idx_q != IDX_LAST |=> idx_q == $past(idx_q) + 5'h1;
   endproperty
   a_casc_step: assert property (p_casc_step) else $error("cascade index not in order");

   property p_casc_publish;
      clk_en && state_q == CASC_PUBLISH |=> cif.results == $past(work_q) && done_q;
   endproperty
   a_casc_publish: assert property (p_casc_publish) else $error("cascade pass not published");

   c_casc_pass: cover property (clk_en && state_q == CASC_PUBLISH);
endmodule : sfa_cascade

// File: sfa_top.sv
// sfa_top: boolean command flags read by the configurable logic equations.
// assumes alarm states, range checks, commands and timers come from logic
// on ref_clk; the operator panel button and breaker replies are pins.
// Contract
// - one flag per alarm class A-F
// - all-classes flag from any class A-F
// - warning flag from class A or B
// - critical flag from class C-F
// - centralized flag from classes B-F
// - new-alarm flag set B-F, held until acknowledge
// - constant false and true flags
// - volt/freq ok per location needs both
// - dead bus while voltage below maximum
// - horn on new alarm, drops after time
// - acknowledge is a roughly 40 ms pulse
// - acknowledge from button or equation output
// - mains breaker closed while reply de-energized
// - group breaker closed while reply de-energized
// - mains settling in group/load-switch mode only
// - group breaker released: dead-bus release or sync
// - sixteen remote-control flags from control word
// - cascaded results evaluated in index order
// - any generator breaker in group closed
// - emergency run request on mains failure
// - breaker open/close/sync activity flags
module sfa_top
   import sfa_pkg::*;
#(
   parameter int NUM_GEN      = 8,
   parameter int MS_TICK      = MS_TICK_CYCLES
)
(
   // clock and control
   input  wire logic                          ref_clk,
   input  wire logic                          reset,
   input  wire logic                          clk_en,
   // alarm states
   input  wire logic [sfa_pkg::NUM_CLASSES-1:0] alarm_class_active,
   input  wire logic [sfa_pkg::NUM_CLASSES-1:0] alarm_class_trig,
   // acknowledge sources
   input  wire logic                          ack_button_pin,
   input  wire logic                          ack_equation,
   // range checks and measurement
   input  wire logic                          gg_volt_ok,
   input  wire logic                          gg_freq_ok,
   input  wire logic                          bus_volt_ok,
   input  wire logic                          bus_freq_ok,
   input  wire logic                          mains_volt_ok,
   input  wire logic                          mains_freq_ok,
   input  wire logic [sfa_pkg::VOLT_W-1:0]    bus_voltage,
   input  wire logic [sfa_pkg::VOLT_W-1:0]    dead_bus_max_volt,
   input  wire logic [sfa_pkg::TIME_W-1:0]    horn_reset_ms,
   // breaker replies (pins) and breaker activity
   input  wire logic                          mains_breaker_reply_input,
   input  wire logic                          group_breaker_reply_input,
   input  wire logic [NUM_GEN-1:0]            generator_breaker_closed,
   input  wire logic                          group_breaker_dead_bus_rel,
   input  wire logic                          group_breaker_sync_busy,
   input  wire logic                          mains_breaker_open_cmd,
   input  wire logic                          mains_breaker_close_cmd,
   input  wire logic                          mains_breaker_sync_req,
   input  wire logic                          group_breaker_open_cmd,
   input  wire logic                          group_breaker_close_cmd,
   input  wire logic                          group_breaker_sync_req,
   // mains supervision
   input  wire logic                          mains_failure,
   input  wire logic                          mains_settle_expired,
   input  wire logic                          group_or_load_switch_mode,
   // remote control word and equation engine
   input  wire logic [sfa_pkg::NUM_REMOTE-1:0] remote_ctrl_word,
   input  wire logic                          casc_val,
   output logic [4:0]                         casc_idx,
   output logic [sfa_pkg::CASC_COUNT-1:0]     casc_work,
   output logic [sfa_pkg::CASC_COUNT-1:0]     casc_results,
   output logic                               casc_pass_done,
   // alarm flags
   output logic [sfa_pkg::NUM_CLASSES-1:0]    class_flags,
   output logic                               all_alarm_flag,
   output logic                               warning_flag,
   output logic                               critical_flag,
   output logic                               central_flag,
   output logic                               new_alarm_flag,
   output logic                               horn_flag,
   output logic                               ack_flag,
   // system condition flags
   output logic                               lm_false,
   output logic                               lm_true,
   output logic                               gg_volt_freq_ok,
   output logic                               bus_volt_freq_ok,
   output logic                               mains_volt_freq_ok,
   output logic                               dead_bus_flag,
   // application flags
   output logic                               mains_breaker_closed,
   output logic                               group_breaker_closed,
   output logic                               mains_settling,
   output logic                               group_breaker_released,
   output logic                               gen_breaker_any_closed,
   output logic                               emerg_run_request,
   output logic                               mains_breaker_open_act,
   output logic                               mains_breaker_close_act,
   output logic                               mains_breaker_sync_act,
   output logic                               group_breaker_open_act,
   output logic                               group_breaker_close_act,
   output logic                               group_breaker_sync_act,
   output logic [sfa_pkg::NUM_REMOTE-1:0]     remote_flags
);
   import sfa_pkg::*;

   localparam logic [MS_CNT_W-1:0] MS_LAST  = MS_CNT_W'(MS_TICK - 1);
   localparam logic [7:0]          ACK_LAST = 8'(ACK_PULSE_MS - 1);

   logic                ack_btn_s1_q, ack_btn_s2_q, ack_btn_s3_q;
   logic                mb_rep_s1_q, mb_rep_s2_q;
   logic                gb_rep_s1_q, gb_rep_s2_q;
   logic                ack_eq_prev_q;
   logic [MS_CNT_W-1:0] ms_cnt_q;
   logic                ms_tick;
   logic                ack_req, new_trig;
   logic [7:0]          ack_ms_q;
   logic [TIME_W-1:0]   horn_ms_q;

   sfa_casc_if casc_link ();

   // cascaded equation sequencer
   sfa_cascade u_cascade (
      .ref_clk (ref_clk),
      .reset   (reset),
      .clk_en  (clk_en),
      .cif     (casc_link.ctrl)
   );

   // engine answer in, sequencer state out
   assign casc_link.val  = casc_val;
   assign casc_idx       = casc_link.idx;
   assign casc_work      = casc_link.work;
   assign casc_results   = casc_link.results;
   assign casc_pass_done = casc_link.pass_done;

   // two-stage synchronisers for the pins
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         ack_btn_s1_q <= FLAG_RST;
         ack_btn_s2_q <= FLAG_RST;
         ack_btn_s3_q <= FLAG_RST;
         mb_rep_s1_q  <= FLAG_RST;
         mb_rep_s2_q  <= FLAG_RST;
         gb_rep_s1_q  <= FLAG_RST;
         gb_rep_s2_q  <= FLAG_RST;
      end
      else if (clk_en)
      begin
         ack_btn_s1_q <= ack_button_pin;
         ack_btn_s2_q <= ack_btn_s1_q;
         ack_btn_s3_q <= ack_btn_s2_q; // edge history
         mb_rep_s1_q  <= mains_breaker_reply_input;
         mb_rep_s2_q  <= mb_rep_s1_q;
         gb_rep_s1_q  <= group_breaker_reply_input;
         gb_rep_s2_q  <= gb_rep_s1_q;
      end
   end

   // millisecond time base
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         ms_cnt_q <= '0;
      else if (clk_en)
         ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 17'h1;
   end
   assign ms_tick = (ms_cnt_q == MS_LAST);

   // acknowledge request on rising edge of either source
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         ack_eq_prev_q <= FLAG_RST;
      else if (clk_en)
         ack_eq_prev_q <= ack_equation;
   end
   assign ack_req  = (ack_btn_s2_q & ~ack_btn_s3_q) | (ack_equation & ~ack_eq_prev_q);
   assign new_trig = |(alarm_class_trig & NEWALM_MASK);

   // acknowledge pulse, stretched over the millisecond count
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         ack_flag <= FLAG_RST;
         ack_ms_q <= '0;
      end
      else if (clk_en)
      begin
         if (ack_req)
         begin
            ack_flag <= 1'h1;
            ack_ms_q <= '0;
         end
         else if (ack_flag && ms_tick)
         begin
            if (ack_ms_q == ACK_LAST)
               ack_flag <= 1'h0;
            else
               ack_ms_q <= ack_ms_q + 8'h1;
         end
      end
   end

   // new-alarm latch; a trigger beats a concurrent acknowledge
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         new_alarm_flag <= FLAG_RST;
      else if (clk_en)
         new_alarm_flag <= new_trig | (new_alarm_flag & ~ack_flag);
   end

   // horn: restarted by each new alarm, dropped after horn_reset_ms
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         horn_flag <= FLAG_RST;
         horn_ms_q <= '0;
      end
      else if (clk_en)
      begin
         if (new_trig)
         begin
            horn_flag <= 1'h1;
            horn_ms_q <= '0;
         end
         else if (horn_flag && ms_tick)
         begin
            if ({1'h0, horn_ms_q} + 17'h1 >= {1'h0, horn_reset_ms})
               horn_flag <= 1'h0;
            else
               horn_ms_q <= horn_ms_q + 16'h1;
         end
      end
   end

   // mains settling; failure beats expiry, forced low outside the mode
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         mains_settling <= FLAG_RST;
      else if (clk_en)
         mains_settling <= group_or_load_switch_mode &
                           (mains_failure | (mains_settling & ~mains_settle_expired));
   end

   // alarm aggregation, recomputed every cycle that clk_en is high
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         class_flags    <= '0;
         all_alarm_flag <= FLAG_RST;
         warning_flag   <= FLAG_RST;
         critical_flag  <= FLAG_RST;
         central_flag   <= FLAG_RST;
      end
      else if (clk_en)
      begin
         class_flags    <= alarm_class_active;
         all_alarm_flag <= |(alarm_class_active & ALL_MASK);
         warning_flag   <= |(alarm_class_active & WARN_MASK);
         critical_flag  <= |(alarm_class_active & CRIT_MASK);
         central_flag   <= |(alarm_class_active & CENTRAL_MASK);
      end
   end

   // range combinations and breaker conditions
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         gg_volt_freq_ok         <= FLAG_RST;
         bus_volt_freq_ok        <= FLAG_RST;
         mains_volt_freq_ok      <= FLAG_RST;
         dead_bus_flag           <= FLAG_RST;
         mains_breaker_closed    <= FLAG_RST;
         group_breaker_closed    <= FLAG_RST;
         group_breaker_released  <= FLAG_RST;
         gen_breaker_any_closed  <= FLAG_RST;
         emerg_run_request       <= FLAG_RST;
         mains_breaker_open_act  <= FLAG_RST;
         mains_breaker_close_act <= FLAG_RST;
         mains_breaker_sync_act  <= FLAG_RST;
         group_breaker_open_act  <= FLAG_RST;
         group_breaker_close_act <= FLAG_RST;
         group_breaker_sync_act  <= FLAG_RST;
      end
      else if (clk_en)
      begin
         gg_volt_freq_ok         <= gg_volt_ok & gg_freq_ok;
         bus_volt_freq_ok        <= bus_volt_ok & bus_freq_ok;
         mains_volt_freq_ok      <= mains_volt_ok & mains_freq_ok;
         dead_bus_flag           <= (bus_voltage < dead_bus_max_volt);
         mains_breaker_closed    <= ~mb_rep_s2_q;
         group_breaker_closed    <= ~gb_rep_s2_q;
         group_breaker_released  <= group_breaker_dead_bus_rel | group_breaker_sync_busy;
         gen_breaker_any_closed  <= |generator_breaker_closed;
         emerg_run_request       <= mains_failure;
         mains_breaker_open_act  <= mains_breaker_open_cmd;
         mains_breaker_close_act <= mains_breaker_close_cmd;
         mains_breaker_sync_act  <= mains_breaker_sync_req;
         group_breaker_open_act  <= group_breaker_open_cmd;
         group_breaker_close_act <= group_breaker_close_cmd;
         group_breaker_sync_act  <= group_breaker_sync_req;
      end
   end

   // remote flag n follows control word bit n
   for (genvar n = 0; n < NUM_REMOTE; n++)
   begin : g_remote
      always_ff @(posedge ref_clk)
      begin
         if (reset)
            remote_flags[n] <= FLAG_RST;
         else if (clk_en)
            remote_flags[n] <= remote_ctrl_word[n];
      end
   end

   // fixed equation defaults
   assign lm_false = LM_FALSE;
   assign lm_true  = LM_TRUE;

   // helper: length of the current acknowledge pulse in cycles
   logic [31:0] ack_hi_cnt_q;
   always_ff @(posedge ref_clk)
   begin
      if (reset || !ack_flag || (clk_en && ack_req))
         ack_hi_cnt_q <= '0; // a restart begins a new pulse
      else if (clk_en)
         ack_hi_cnt_q <= ack_hi_cnt_q + 32'h1;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   property p_class;
      $past(clk_en & ~reset) |-> class_flags == $past(alarm_class_active);
   endproperty
   a_class: assert property (p_class) else $error("class flag mismatch");

   property p_groups;
      all_alarm_flag == |class_flags && warning_flag == (class_flags[0] | class_flags[1]);
   endproperty
   a_groups: assert property (p_groups) else $error("all or warning flag wrong");

   property p_critical;
      critical_flag == |class_flags[5:2];
   endproperty
   a_critical: assert property (p_critical) else $error("critical flag wrong");

   property p_central;
      central_flag == |class_flags[5:1];
   endproperty
   a_central: assert property (p_central) else $error("centralized flag wrong");

   property p_newalm;
      clk_en && new_trig |=> new_alarm_flag && horn_flag;
   endproperty
   a_newalm: assert property (p_newalm) else $error("new alarm or horn not set");

   property p_newalm_hold;
      new_alarm_flag && !ack_flag |=> new_alarm_flag;
   endproperty
   a_newalm_hold: assert property (p_newalm_hold) else $error("new alarm lost");

   property p_range;
      $past(clk_en & ~reset) |-> mains_volt_freq_ok == $past(mains_volt_ok && mains_freq_ok)
                     && dead_bus_flag == $past(bus_voltage < dead_bus_max_volt);
   endproperty
   a_range: assert property (p_range) else $error("range or dead bus flag wrong");

   property p_ack_start;
      clk_en && ack_req |=> ack_flag;
   endproperty
   a_ack_start: assert property (p_ack_start) else $error("acknowledge not raised");

   property p_ack_len;
      ack_hi_cnt_q <= 32'(ACK_PULSE_MS * MS_TICK);
   endproperty
   a_ack_len: assert property (p_ack_len) else $error("acknowledge pulse too long");

   property p_breakers;
      $past(clk_en & ~reset) |-> mains_breaker_closed == !$past(mb_rep_s2_q)
                     && group_breaker_closed == !$past(gb_rep_s2_q);
   endproperty
   a_breakers: assert property (p_breakers) else $error("breaker reply decode wrong");

   property p_settle_mode;
      clk_en && !group_or_load_switch_mode |=> !mains_settling;
   endproperty
   a_settle_mode: assert property (p_settle_mode) else $error("settling outside mode");

   property p_remote;
      $past(clk_en & ~reset) |-> remote_flags == $past(remote_ctrl_word)
                              && emerg_run_request == $past(mains_failure);
   endproperty
   a_remote: assert property (p_remote) else $error("remote or emergency flag wrong");

   c_horn_drop: cover property (horn_flag ##1 !horn_flag);
   c_ack_pulse: cover property (ack_flag ##1 !ack_flag);
   c_settle:    cover property (mains_settling ##1 !mains_settling);
endmodule : sfa_top

// File: sfa_engine_model.sv
// sfa_engine_model: equation engine answering the cascade sequencer.
// assumes casc_idx and casc_work come from sfa_top registers.
module sfa_engine_model
   import sfa_pkg::*;
(
   // cascade link
   input  wire logic [4:0]                     casc_idx,
   input  wire logic [sfa_pkg::CASC_COUNT-1:0] casc_work,
   output logic                                casc_val
);
   import sfa_pkg::*;

   // equation 0 is true, each later equation reads the one just before it from this pass
   assign casc_val = (casc_idx == 5'h00) ? 1'b1 :
                     (casc_work[casc_idx - 5'h01] ^ casc_idx[0]);
endmodule : sfa_engine_model

// File: sfa_top_tb.sv
// sfa_top_tb: random and directed stimulus checked against a bench model.
// assumes sfa_top with MS_TICK shortened to 10 cycles per millisecond.
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module sfa_top_tb
   import sfa_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk, reset, clk_en, ack_button_pin, ack_equation, casc_val, st;
   logic        casc_pass_done, all_alarm_flag, warning_flag, critical_flag, central_flag;
   logic        new_alarm_flag, horn_flag, ack_flag, lm_false, lm_true, dead_bus_flag;
   logic        mains_settling, group_breaker_released, gen_breaker_any_closed, emerg_run_request;
   logic [1:0]  pin, pb, pc;
   logic [2:0]  mis, vf;
   logic [5:0]  alarm_class_active, alarm_class_trig, class_flags, ok, cmd, act;
   logic [15:0] bus_voltage, dead_bus_max_volt, horn_reset_ms, remote_ctrl_word, remote_flags;
   logic [7:0]  generator_breaker_closed;
   logic [4:0]  casc_idx;
   logic [19:0] casc_work, casc_results, ce;
   int          fail_count = 0, comparisons = 0, n;

   sfa_engine_model u_sfa_engine_model (.casc_idx, .casc_work, .casc_val);
   sfa_top #(.MS_TICK(10)) u_sfa_top (.ref_clk, .reset, .clk_en, .alarm_class_active,
      .alarm_class_trig, .ack_button_pin, .ack_equation, .gg_volt_ok(ok[0]), .gg_freq_ok(ok[1]),
      .bus_volt_ok(ok[2]), .bus_freq_ok(ok[3]), .mains_volt_ok(ok[4]), .mains_freq_ok(ok[5]),
      .bus_voltage, .dead_bus_max_volt, .horn_reset_ms, .mains_breaker_reply_input(pin[0]),
      .group_breaker_reply_input(pin[1]), .generator_breaker_closed,
      .group_breaker_dead_bus_rel(mis[0]), .group_breaker_sync_busy(mis[1]),
      .mains_breaker_open_cmd(cmd[0]), .mains_breaker_close_cmd(cmd[1]),
      .mains_breaker_sync_req(cmd[2]), .group_breaker_open_cmd(cmd[3]),
      .group_breaker_close_cmd(cmd[4]), .group_breaker_sync_req(cmd[5]),
      .mains_failure(mis[2]), .mains_settle_expired(ok[0]), .group_or_load_switch_mode(ok[1]),
      .remote_ctrl_word, .casc_val, .casc_idx, .casc_work, .casc_results, .casc_pass_done,
      .class_flags, .all_alarm_flag, .warning_flag, .critical_flag, .central_flag,
      .new_alarm_flag, .horn_flag, .ack_flag, .lm_false, .lm_true,
      .gg_volt_freq_ok(vf[0]), .bus_volt_freq_ok(vf[1]), .mains_volt_freq_ok(vf[2]),
      .dead_bus_flag, .mains_breaker_closed(pc[0]), .group_breaker_closed(pc[1]),
      .mains_settling, .group_breaker_released, .gen_breaker_any_closed, .emerg_run_request,
      .mains_breaker_open_act(act[0]), .mains_breaker_close_act(act[1]),
      .mains_breaker_sync_act(act[2]), .group_breaker_open_act(act[3]),
      .group_breaker_close_act(act[4]), .group_breaker_sync_act(act[5]), .remote_flags);

   // free-running clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // one cycle, inputs move 1 ns after the edge
   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask : step

   // verdict and end of run
   task automatic complete_run();
      if (fail_count == 0 && comparisons > 0)
      begin
         $display("== PASSED ==");
      end
      else
      begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run

   // cut a hang short
   initial
   begin
      #100us;
      fail_count++;
      complete_run();
   end

   // main sequence
   initial
   begin
      {reset, clk_en, ack_button_pin, ack_equation, alarm_class_active, alarm_class_trig} = '1;
      {ack_button_pin, ack_equation, alarm_class_active, alarm_class_trig, ok, mis, cmd} = '0;
      {pin, bus_voltage, dead_bus_max_volt, remote_ctrl_word, generator_breaker_closed} = '0;
      horn_reset_ms = 16'h0002;
      st = 1'b0;
      void'($urandom(32'hAF01));
      repeat (3) step();
      `CHK({new_alarm_flag, horn_flag, ack_flag, lm_true, casc_idx}, 9'h020)
      reset = 1'b0;
      // random levels against the bench model, pins three cycles late
      for (n = 0; n < 300; n++)
      begin
         pb = pin;
         {alarm_class_active, ok, mis, cmd, pin} = $urandom;
         {bus_voltage, dead_bus_max_volt} = $urandom;
         {remote_ctrl_word, generator_breaker_closed} = $urandom;
         st = ok[1] & (mis[2] | (st & ~ok[0]));
         step();
         `CHK(class_flags, alarm_class_active)
         `CHK(all_alarm_flag, |alarm_class_active)
         `CHK(warning_flag, |(alarm_class_active & WARN_MASK))
         `CHK(critical_flag, |(alarm_class_active & CRIT_MASK))
         `CHK(central_flag, |(alarm_class_active & CENTRAL_MASK))
         `CHK({lm_false, lm_true}, 2'h1)
         `CHK(vf, {ok[5] & ok[4], ok[3] & ok[2], ok[1] & ok[0]})
         `CHK(dead_bus_flag, bus_voltage < dead_bus_max_volt)
         if (n > 2) `CHK(pc, ~pb)
         `CHK(mains_settling, st)
         `CHK(group_breaker_released, mis[0] | mis[1])
         `CHK(remote_flags, remote_ctrl_word)
         `CHK(gen_breaker_any_closed, |generator_breaker_closed)
         `CHK(emerg_run_request, mis[2])
         `CHK(act, cmd)
         pb = pin;
         step();
      end
      // cascade: result 0 is set, each later result chains from the one before it
      ce[0] = 1'b1;
      for (n = 1; n < 20; n++) ce[n] = ce[n - 1] ^ n[0];
      for (n = 0; n < 30 && casc_pass_done !== 1'b1; n++) step();
      `CHK(casc_results, ce)
      // class A trigger alone raises nothing, class E raises both
      alarm_class_trig = 6'h01;
      step();
      alarm_class_trig = 6'h10;
      `CHK({new_alarm_flag, horn_flag}, 2'h0)
      step();
      alarm_class_trig = 6'h00;
      `CHK({new_alarm_flag, horn_flag}, 2'h3)
      repeat (9) step();
      `CHK(horn_flag, 1'b1)
      repeat (12) step();
      `CHK({new_alarm_flag, horn_flag}, 2'h2)
      // acknowledge pulse clears the new-alarm latch
      ack_equation = 1'b1;
      step();
      ack_equation = 1'b0;
      `CHK(ack_flag, 1'b1)
      step();
      `CHK(new_alarm_flag, 1'b0)
      repeat (388) step();
      `CHK(ack_flag, 1'b1)
      repeat (12) step();
      `CHK(ack_flag, 1'b0)
      // panel button edge reaches the flag three cycles later
      ack_button_pin = 1'b1;
      repeat (2) step();
      `CHK(ack_flag, 1'b0)
      step();
      `CHK(ack_flag, 1'b1)
      // clk_en low freezes the class and new-alarm flags, a trigger then beats the acknowledge
      clk_en = 1'b0;
      alarm_class_active = ~alarm_class_active;
      alarm_class_trig = 6'h02;
      repeat (5) step();
      `CHK({class_flags, new_alarm_flag}, {~alarm_class_active, 1'b0})
      clk_en = 1'b1;
      step();
      alarm_class_trig = 6'h00;
      `CHK({class_flags, new_alarm_flag}, {alarm_class_active, 1'b1})
      // mid-run reset clears the latches at once
      reset = 1'b1;
      step();
      `CHK({new_alarm_flag, horn_flag, ack_flag, casc_idx}, 8'h00)
      reset = 1'b0;
      ack_button_pin = 1'b0;
      step();
      `CHK(class_flags, alarm_class_active)
      complete_run();
   end
endmodule : sfa_top_tb
